// ==== hw/lim_map.svh ====
`ifndef LIM_MAP_SVH
`define LIM_MAP_SVH

// ----------------------------------------
// Instruction word layout
// ----------------------------------------
`define LIM_IW 14
`define LIM_NOP_CODE 14'h0000
`define LIM_OPTION_CODE 14'h0062
// Load bank literal: bits 13:5 match, literal in 4:0
`define LIM_LBL_MATCH 9'h001
`define LIM_LBL_KW 5
// Load page latch literal: bits 13:7 match, literal in 6:0
`define LIM_LPL_MATCH 7'h63
`define LIM_LPL_KW 7
// Load work literal: bits 13:8 match, literal in 7:0
`define LIM_LWL_MATCH 6'h30
// Store work to file: bits 13:7 match, address in 6:0
`define LIM_SWF_MATCH 7'h01
`define LIM_FA_W 7
// Store work indirect, update form: bits 13:3 match, n in 2, mode in 1:0
`define LIM_SWI_MATCH 11'h003
// Store work indirect, offset form: bits 13:7 match, n in 6, offset in 5:0
`define LIM_SWO_MATCH 7'h7F
`define LIM_OFS_W 6

// ----------------------------------------
// Pointer update mode codes
// ----------------------------------------
`define LIM_MODE_PRE_INC 2'h0
`define LIM_MODE_PRE_DEC 2'h1
`define LIM_MODE_POST_INC 2'h2
`define LIM_MODE_POST_DEC 2'h3

// ----------------------------------------
// Addresses and reset values
// ----------------------------------------
`define LIM_PTR_W 16
`define LIM_WIN0_ADDR 7'h00
`define LIM_WIN1_ADDR 7'h01
`define LIM_PTR_STEP 16'h0001
`define LIM_WORK_RST 8'h00
`define LIM_BANK_RST 5'h00
`define LIM_PCH_RST 7'h00
`define LIM_OPT_RST 8'hFF
`define LIM_PTR_RST 16'h0000
`define LIM_PC_RST 15'h0000
`define LIM_PC_STEP 15'h0001

`endif

// ==== hw/lim_pkg.sv ====
`default_nettype none
package lim_pkg;
  // Decoded instruction class
  typedef enum logic [3:0] {
    LIM_OP_NOP,
    LIM_OP_LBL,
    LIM_OP_LPL,
    LIM_OP_LWL,
    LIM_OP_SWF,
    LIM_OP_SWI,
    LIM_OP_SWO,
    LIM_OP_OPT,
    LIM_OP_BAD
  } lim_op_t;
endpackage
`default_nettype wire

// ==== hw/lim_mem_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Data memory carrier between the core and its storage
interface lim_mem_if #(parameter int AW = 12);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ==== hw/lim_data_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module lim_data_mem #(
  parameter int AW = 12
) (
  // Clock and freeze
  input wire logic clk,
  input wire logic ce,
  // Memory port
  lim_mem_if.mem bus
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Zero width is no memory; beyond the pointer width nothing can reach it
  if (AW < 1 || AW > 16) begin : g_bad_aw
    $error("AW must lie between 1 and 16");
  end

  logic [7:0] store [0:(1<<AW)-1];
  logic [7:0] rdata_r;

  // ----------------------------------------
  // Storage, registered read
  // ----------------------------------------
  // No reset on contents; only the read register is observed
  always_ff @(posedge clk) begin
    if (ce) begin
      if (bus.we) begin
        store[bus.waddr] <= bus.wdata;
      end
      rdata_r <= store[bus.raddr];
    end
  end

  assign bus.rdata = rdata_r;
endmodule
`default_nettype wire

// ==== hw/lim_core.sv ====
// What this block does
// - Load bank literal writes its 5-bit literal to the bank select register, no flags move.
// - Load page latch literal copies its 7-bit literal into the pc high latch, flags untouched.
// - Load work literal puts its 8-bit literal into the work register, flags untouched.
// - Store work to file writes the work register to the 7-bit file address in the bank.
// - Store work indirect writes the work register to the address held by pointer 0 or 1.
// - Mode 00 pre-increments, 01 pre-decrements, 10 post-increments, 11 post-decrements.
// - Offset form addresses pointer plus a signed -32..31 offset and leaves the pointer.
// - After an indirect store the pointer is old plus one, old minus one, or unchanged.
// - Pointer arithmetic is 16-bit modular and wraps at both ends.
// - Pointer updates change no status flag.
// - The indirect window addresses have no storage and redirect through their pointer.
// - Load option copies the work register into the option register, flags untouched.
`timescale 1ns/1ps
`default_nettype none
`include "lim_map.svh"
module lim_core #(
  parameter int MEM_AW = 12
) (
  // Clock, reset, freeze
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [`LIM_IW-1:0] instr,
  // Memory inspection
  input wire logic [MEM_AW-1:0] peek_addr,
  output logic [7:0] peek_data,
  // Core registers
  output logic [7:0] work,
  output logic [`LIM_LBL_KW-1:0] bank_select_register,
  output logic [`LIM_LPL_KW-1:0] pc_high_latch,
  output logic [7:0] option_ctrl,
  output logic [`LIM_PTR_W-1:0] file_pointer0,
  output logic [`LIM_PTR_W-1:0] file_pointer1,
  output logic [14:0] pc,
  // Store trace and decode status
  output logic store_done,
  output logic [`LIM_PTR_W-1:0] store_addr,
  output logic [7:0] store_data,
  output logic illegal_op
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Memory cannot be wider than the pointer space
  if (MEM_AW < 1 || MEM_AW > `LIM_PTR_W) begin : g_bad_aw
    $error("MEM_AW must lie between 1 and 16");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] work_r, work_nxt;
  logic [`LIM_LBL_KW-1:0] bank_r, bank_nxt;
  logic [`LIM_LPL_KW-1:0] pch_r, pch_nxt;
  logic [7:0] opt_r, opt_nxt;
  logic [`LIM_PTR_W-1:0] ptr_r [2];
  logic [`LIM_PTR_W-1:0] ptr_nxt [2];
  logic [14:0] pc_r, pc_nxt;
  logic st_r, st_nxt;
  logic [`LIM_PTR_W-1:0] sa_r, sa_nxt;
  logic [7:0] sd_r, sd_nxt;
  logic bad_r, bad_nxt;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  lim_pkg::lim_op_t op;
  logic sel;
  logic [1:0] mode;
  logic [`LIM_PTR_W-1:0] cur, inc, dec, ofs_sum, ea;
  logic [`LIM_PTR_W-1:0] ofs_ext;
  logic ptr_we;
  logic [`LIM_PTR_W-1:0] ptr_new;
  logic mem_we;

  // Instruction class by field match
  always_comb begin
    if (instr == `LIM_NOP_CODE) begin
      op = lim_pkg::LIM_OP_NOP;
    end else if (instr == `LIM_OPTION_CODE) begin
      op = lim_pkg::LIM_OP_OPT;
    end else if (instr[13:5] == `LIM_LBL_MATCH) begin
      op = lim_pkg::LIM_OP_LBL;
    end else if (instr[13:7] == `LIM_LPL_MATCH) begin
      op = lim_pkg::LIM_OP_LPL;
    end else if (instr[13:8] == `LIM_LWL_MATCH) begin
      op = lim_pkg::LIM_OP_LWL;
    end else if (instr[13:7] == `LIM_SWF_MATCH) begin
      op = lim_pkg::LIM_OP_SWF;
    end else if (instr[13:3] == `LIM_SWI_MATCH) begin
      op = lim_pkg::LIM_OP_SWI;
    end else if (instr[13:7] == `LIM_SWO_MATCH) begin
      op = lim_pkg::LIM_OP_SWO;
    end else begin
      op = lim_pkg::LIM_OP_BAD;
    end
  end

  // Pointer select, arithmetic and effective address
  always_comb begin
    sel = (op == lim_pkg::LIM_OP_SWO) ? instr[6] : instr[2];
    mode = instr[1:0];
    cur = ptr_r[sel];
    inc = cur + `LIM_PTR_STEP;
    dec = cur - `LIM_PTR_STEP;
    ofs_ext = {{(`LIM_PTR_W-`LIM_OFS_W){instr[5]}}, instr[`LIM_OFS_W-1:0]};
    ofs_sum = cur + ofs_ext;
    ea = cur;
    ptr_we = 1'b0;
    ptr_new = cur;
    mem_we = 1'b0;
    unique case (op)
      lim_pkg::LIM_OP_SWI: begin
        mem_we = 1'b1;
        ptr_we = 1'b1;
        unique case (mode)
          `LIM_MODE_PRE_INC: begin
            ptr_new = inc;
            ea = inc;
          end
          `LIM_MODE_PRE_DEC: begin
            ptr_new = dec;
            ea = dec;
          end
          `LIM_MODE_POST_INC: begin
            ptr_new = inc;
            ea = cur;
          end
          `LIM_MODE_POST_DEC: begin
            ptr_new = dec;
            ea = cur;
          end
        endcase
      end
      lim_pkg::LIM_OP_SWO: begin
        mem_we = 1'b1;
        ea = ofs_sum;
      end
      lim_pkg::LIM_OP_SWF: begin
        mem_we = 1'b1;
        if (instr[6:0] == `LIM_WIN0_ADDR) begin
          ea = ptr_r[0];
        end else if (instr[6:0] == `LIM_WIN1_ADDR) begin
          ea = ptr_r[1];
        end else begin
          ea = {{(`LIM_PTR_W-`LIM_LBL_KW-`LIM_FA_W){1'b0}}, bank_r, instr[6:0]};
        end
      end
      default: begin
        ea = cur;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Flags are not part of this path, so none of these ops can disturb them
  always_comb begin
    work_nxt = work_r;
    bank_nxt = bank_r;
    pch_nxt = pch_r;
    opt_nxt = opt_r;
    ptr_nxt[0] = ptr_r[0];
    ptr_nxt[1] = ptr_r[1];
    pc_nxt = pc_r;
    st_nxt = 1'b0;
    sa_nxt = sa_r;
    sd_nxt = sd_r;
    bad_nxt = bad_r;
    if (instr_valid) begin
      pc_nxt = pc_r + `LIM_PC_STEP;
      bad_nxt = (op == lim_pkg::LIM_OP_BAD);
      unique case (op)
        lim_pkg::LIM_OP_LBL: bank_nxt = instr[`LIM_LBL_KW-1:0];
        lim_pkg::LIM_OP_LPL: pch_nxt = instr[`LIM_LPL_KW-1:0];
        lim_pkg::LIM_OP_LWL: work_nxt = instr[7:0];
        lim_pkg::LIM_OP_OPT: opt_nxt = work_r;
        default: begin
          bank_nxt = bank_r;
        end
      endcase
      if (ptr_we) begin
        ptr_nxt[sel] = ptr_new;
      end
      if (mem_we) begin
        st_nxt = 1'b1;
        sa_nxt = ea;
        sd_nxt = work_r;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      work_r <= `LIM_WORK_RST;
      bank_r <= `LIM_BANK_RST;
      pch_r <= `LIM_PCH_RST;
      opt_r <= `LIM_OPT_RST;
      pc_r <= `LIM_PC_RST;
      st_r <= 1'b0;
      sa_r <= `LIM_PTR_RST;
      sd_r <= `LIM_WORK_RST;
      bad_r <= 1'b0;
    end else if (ce) begin
      work_r <= work_nxt;
      bank_r <= bank_nxt;
      pch_r <= pch_nxt;
      opt_r <= opt_nxt;
      pc_r <= pc_nxt;
      st_r <= st_nxt;
      sa_r <= sa_nxt;
      sd_r <= sd_nxt;
      bad_r <= bad_nxt;
    end
  end

  // Both pointers, one register each
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        ptr_r[i] <= `LIM_PTR_RST;
      end else if (ce) begin
        ptr_r[i] <= ptr_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Data memory
  // ----------------------------------------
  // Write is issued from the registered trace, one cycle after decode
  lim_mem_if #(.AW(MEM_AW)) mbus ();
  assign mbus.we = st_r;
  assign mbus.waddr = sa_r[MEM_AW-1:0];
  assign mbus.wdata = sd_r;
  assign mbus.raddr = peek_addr;

  lim_data_mem #(.AW(MEM_AW)) lim_data_mem_inst (
    .clk(clk),
    .ce(ce),
    .bus(mbus.mem)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign peek_data = mbus.rdata;
  assign work = work_r;
  assign bank_select_register = bank_r;
  assign pc_high_latch = pch_r;
  assign option_ctrl = opt_r;
  assign file_pointer0 = ptr_r[0];
  assign file_pointer1 = ptr_r[1];
  assign pc = pc_r;
  assign store_done = st_r;
  assign store_addr = sa_r;
  assign store_data = sd_r;
  assign illegal_op = bad_r;
endmodule
`default_nettype wire

// ==== verif/lim_core_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module lim_core_checker (
  // Clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  // Observed state
  input wire logic [7:0] work,
  input wire logic [4:0] bank_select_register,
  input wire logic [6:0] pc_high_latch,
  input wire logic [7:0] option_ctrl,
  input wire logic [15:0] file_pointer0,
  input wire logic [15:0] file_pointer1,
  input wire logic [14:0] pc,
  input wire logic store_done,
  input wire logic [15:0] store_addr,
  input wire logic [7:0] store_data
);
  // ----------------------------------------
  // Decoded views, offset sign-extended here
  // ----------------------------------------
  logic go;
  logic [15:0] upd_old, upd_new, ofs_ptr, win_ptr;
  assign go = ce && instr_valid;
  assign upd_old = instr[2] ? file_pointer1 : file_pointer0;
  assign upd_new = upd_old + (instr[0] ? 16'hFFFF : 16'h0001);
  assign ofs_ptr = (instr[6] ? file_pointer1 : file_pointer0) + {{10{instr[5]}}, instr[5:0]};
  assign win_ptr = instr[0] ? file_pointer1 : file_pointer0;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_BANK: assert property (go && instr[13:5] == 9'h001
    |=> bank_select_register == $past(instr[4:0])) else $error("bank literal lost");
  AST_PAGE: assert property (go && instr[13:7] == 7'h63
    |=> pc_high_latch == $past(instr[6:0])) else $error("page literal lost");
  AST_WORK: assert property (go && instr[13:8] == 6'h30
    |=> work == $past(instr[7:0])) else $error("work literal lost");
  AST_FILE: assert property (go && instr[13:7] == 7'h01 && instr[6:1] != 6'h00
    |=> store_done && store_data == $past(work)
    && store_addr == {4'h0, $past(bank_select_register), $past(instr[6:0])})
    else $error("direct store wrong");
  AST_UPD: assert property (go && instr[13:3] == 11'h003
    |=> store_addr == $past(instr[1] ? upd_old : upd_new) && store_data == $past(work)
    && ($past(instr[2]) ? file_pointer1 : file_pointer0) == $past(upd_new))
    else $error("indirect update store wrong");
  AST_OFS: assert property (go && instr[13:7] == 7'h7F
    |=> store_addr == $past(ofs_ptr) && $stable(file_pointer0) && $stable(file_pointer1))
    else $error("offset store wrong");
  AST_WIN: assert property (go && instr[13:1] == 13'h0040
    |=> store_addr == $past(win_ptr) && $stable(file_pointer0) && $stable(file_pointer1))
    else $error("window not redirected");
  AST_OPT: assert property (go && instr == 14'h0062
    |=> option_ctrl == $past(work)) else $error("option not loaded");
  AST_NOP: assert property (go && instr == 14'h0000
    |=> pc == $past(pc) + 15'h0001 && !store_done && $stable(work))
    else $error("idle word changed state");
  // Main scenarios reached
  cover property (go && instr[13:3] == 11'h003);
  cover property (store_done && store_addr == 16'hFFFF);
  cover property (go && instr == 14'h0000);
endmodule
bind lim_core lim_core_checker lim_core_checker_inst (.clk(clk), .reset_n(reset_n),
  .ce(ce), .instr_valid(instr_valid), .instr(instr), .work(work),
  .bank_select_register(bank_select_register), .pc_high_latch(pc_high_latch),
  .option_ctrl(option_ctrl), .file_pointer0(file_pointer0), .file_pointer1(file_pointer1),
  .pc(pc), .store_done(store_done), .store_addr(store_addr), .store_data(store_data));
`default_nettype wire

// ==== verif/tb_lim_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_lim_core;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk, reset_n, ce, instr_valid, store_done, illegal_op;
  logic [13:0] instr;
  logic [11:0] peek_addr;
  logic [7:0] peek_data, work, option_ctrl, store_data;
  logic [4:0] bank_select_register;
  logic [6:0] pc_high_latch;
  logic [15:0] file_pointer0, file_pointer1, store_addr;
  logic [14:0] pc, exp_pc;
  int fails, checks_done;
  // Rows: word, store address, pointer 0, pointer 1 after the store
  localparam logic [63:0] TBL [8] = '{64'h001D_FFFF_0000_FFFF, 64'h001A_0000_0001_FFFF,
    64'h0018_0002_0002_FFFF, 64'h001E_FFFF_0002_0000, 64'h001B_0002_0001_0000,
    64'h001F_0000_0001_FFFF, 64'h3FA0_FFE1_0001_FFFF, 64'h3FDF_001E_0001_FFFF};
  lim_core #(.MEM_AW(12)) lim_core_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
    .instr_valid(instr_valid), .instr(instr), .peek_addr(peek_addr), .peek_data(peek_data),
    .work(work), .bank_select_register(bank_select_register), .pc_high_latch(pc_high_latch),
    .option_ctrl(option_ctrl), .file_pointer0(file_pointer0), .file_pointer1(file_pointer1),
    .pc(pc), .store_done(store_done), .store_addr(store_addr), .store_data(store_data),
    .illegal_op(illegal_op));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Valid stays high so words can run back to back
  task automatic exec(input logic [13:0] w);
    instr = w;
    instr_valid = 1'b1;
    @(posedge clk);
    #1;
    exp_pc = exp_pc + 15'h0001;
  endtask
  task automatic idle(input int n);
    instr_valid = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Memory lags the store by one edge, the read register by one more
  task automatic mem_chk(input logic [11:0] a, input logic [7:0] d);
    peek_addr = a;
    idle(3);
    chk(peek_data, d);
  endtask
  task automatic t_reset();
    chk(work, 8'h00);
    chk(option_ctrl, 8'hFF);
    chk(file_pointer0 | file_pointer1, 16'h0000);
    chk(store_done, 1'b0);
  endtask
  task automatic t_literals();
    exec(14'h003F);
    exec(14'h31FF);
    exec(14'h30A5);
    chk(bank_select_register, 5'h1F);
    chk(pc_high_latch, 7'h7F);
    chk(work, 8'hA5);
  endtask
  task automatic t_option();
    exec(14'h304F);
    exec(14'h0062);
    chk(option_ctrl, 8'h4F);
    exec(14'h303C);
    exec(14'h0062);
    chk(option_ctrl, 8'h3C);
  endtask
  task automatic t_store_file();
    exec(14'h0022);
    exec(14'h30C3);
    exec(14'h00FF);
    chk(store_done, 1'b1);
    chk(store_addr, 16'h017F);
    mem_chk(12'h17F, 8'hC3);
  endtask
  task automatic t_indirect();
    exec(14'h3055);
    for (int i = 0; i < 8; i++) begin
      exec(TBL[i][61:48]);
      chk(store_addr, TBL[i][47:32]);
      chk(file_pointer0, TBL[i][31:16]);
      chk(file_pointer1, TBL[i][15:0]);
      chk(store_data, 8'h55);
    end
    mem_chk(12'h01E, 8'h55);
  endtask
  task automatic t_window();
    exec(14'h3077);
    exec(14'h0080);
    chk(store_addr, 16'h0001);
    exec(14'h0081);
    chk(store_addr, 16'hFFFF);
    chk(file_pointer0, 16'h0001);
    mem_chk(12'h001, 8'h77);
  endtask
  // Freeze must hold every register even with a valid word waiting
  task automatic t_freeze();
    ce = 1'b0;
    exec(14'h30EE);
    exp_pc = exp_pc - 15'h0001;
    chk(work, 8'h77);
    chk(pc, exp_pc);
    ce = 1'b1;
  endtask
  task automatic t_nop();
    exec(14'h0001);
    chk(illegal_op, 1'b1);
    exec(14'h0000);
    chk(illegal_op, 1'b0);
    chk(pc, exp_pc);
    chk(work, 8'h77);
    chk(store_done, 1'b0);
    chk(file_pointer0, 16'h0001);
    chk(option_ctrl, 8'h3C);
  endtask
  // Mid-run reset must bring back every reset value
  task automatic t_rearm();
    reset_n = 1'b0;
    idle(2);
    reset_n = 1'b1;
    chk(work, 8'h00);
    chk(option_ctrl, 8'hFF);
    chk(file_pointer0, 16'h0000);
    chk(bank_select_register, 5'h00);
    chk(pc_high_latch, 7'h00);
    chk(pc, 15'h0000);
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    instr_valid = 1'b0;
    instr = 14'h0000;
    peek_addr = 12'h000;
    fails = 0;
    checks_done = 0;
    exp_pc = 15'h0000;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_literals();
    t_option();
    t_store_file();
    t_indirect();
    t_window();
    t_freeze();
    t_nop();
    t_rearm();
    tally_and_finish();
  end
endmodule
`default_nettype wire
